/* logic/sfp_regs.svh */
// Purpose: constants for the scan port fan-out block
// Assumes: included by its bare name
// Notes: sync bank bit positions, reset values, counts
`ifndef SFP_REGS_SVH
`define SFP_REGS_SVH

`define SFP_LOCAL_N 6
`define SFP_SLOT_W 8
`define SFP_SEL_W 7
`define SFP_FLAG_N 5
`define SFP_SY_W 32
`define SFP_SY_TCK 0
`define SFP_SY_TMS 2
`define SFP_SY_TRST 4
`define SFP_SY_TDI 6
`define SFP_SY_PT0 8
`define SFP_SY_PT1 10
`define SFP_SY_MPS 12
`define SFP_SY_SLOT 13
`define SFP_SY_OEN 21
`define SFP_SY_IDLE 22
`define SFP_SY_MASK 23
`define SFP_SY_LTDI 24
`define SFP_SY_LPT0 30
`define SFP_SY_LPT1 31
`define SFP_SY_RST 32'h00000000
`define SFP_TLR_LAST 3'h4
`define SFP_SEL_RST 7'h00
`define SFP_FLAG_RST 5'h1f
`define SFP_SLOT_RST 8'h00

`endif

/* logic/sfp_pkg.sv */
// Purpose: shared types of the scan port fan-out block
// Assumes: nothing
// Notes: port 00 is bit 0 of the selection vector
package sfp_pkg;
  typedef logic [6:0] sfp_sel_t;
  typedef logic [2:0] sfp_idx_t;
  typedef enum logic [0:0] {
    SFP_TAP_RUN = 1'b0,
    SFP_TAP_TLR = 1'b1
  } sfp_tap_st_t;
endpackage

/* logic/sfp_sel_if.sv */
// Purpose: carries port selection and its decode between modules
// Assumes: one owner, one decoder
// Notes: purely combinational
`timescale 1ns/1ps
interface sfp_sel_if;
  sfp_pkg::sfp_sel_t sel;
  logic any;
  logic single;
  sfp_pkg::sfp_idx_t idx;
  modport decoder (input sel, output any, output single, output idx);
  modport owner (output sel, input any, input single, input idx);
endinterface

/* logic/sfp_sync.sv */
// Purpose: two-flop synchroniser bank for pin inputs
// Assumes: inputs asynchronous to clk_sys
// Notes: first stage feeds only the second
`timescale 1ns/1ps
`include "sfp_regs.svh"
module sfp_sync #(
  parameter int WIDTH = `SFP_SY_W
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] hold_ff;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= '0;
      hold_ff <= '0;
    end else begin
      meta_ff <= d_in;
      hold_ff <= meta_ff;
    end
  end

  assign q_out = hold_ff;
endmodule

/* logic/sfp_port_sel.sv */
// Purpose: decodes the local port selection vector
// Assumes: selection from same-clock logic
// Notes: idx is the lowest selected port
`timescale 1ns/1ps
module sfp_port_sel (
  sfp_sel_if.decoder sif
);
  function automatic logic [2:0] ones(input sfp_pkg::sfp_sel_t v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 7; i++) begin
      n = n + {2'h0, v[i]};
    end
    return n;
  endfunction

  function automatic sfp_pkg::sfp_idx_t low_idx(input sfp_pkg::sfp_sel_t v);
    sfp_pkg::sfp_idx_t r;
    r = 3'h0;
    for (int i = 6; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  always_comb begin
    sif.any = |sif.sel;
    sif.single = (ones(sif.sel) == 3'h1);
    sif.idx = low_idx(sif.sel);
  end
endmodule

/* logic/sfp_fanout.sv */
// Purpose: local scan port fan-out and pass-through routing
// Assumes: pins sampled on clk_sys, tck far slower than clk_sys
// Notes: addressing and mode logic outside; selection arrives ready
`timescale 1ns/1ps
`include "sfp_regs.svh"
module sfp_fanout (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [1:0] bp_tck_in,
  output logic [1:0] bp_tck_out,
  output logic [1:0] bp_tck_oe,
  input wire logic [1:0] bp_tms_in,
  output logic [1:0] bp_tms_out,
  output logic [1:0] bp_tms_oe,
  input wire logic [1:0] bp_trst_n_in,
  output logic [1:0] bp_trst_n_out,
  output logic [1:0] bp_trst_n_oe,
  input wire logic [1:0] bp_tdi_in,
  output logic [1:0] bp_tdo_out,
  output logic [1:0] bp_tdo_oe,
  input wire logic [1:0] backplane_passthru_in0,
  input wire logic [1:0] backplane_passthru_in1,
  output logic [1:0] backplane_passthru_out0,
  output logic [1:0] backplane_passthru_out1,
  output logic [1:0] backplane_passthru_oe,
  input wire logic master_port_select,
  input wire logic [`SFP_SLOT_W-1:0] slot_id,
  output logic [`SFP_SLOT_W-1:0] slot_addr,
  input wire logic output_enable_n,
  input wire logic idle_reset_level,
  input wire logic backplane_reset_mask,
  input wire logic [`SFP_SEL_W-1:0] port_select,
  output logic [`SFP_LOCAL_N-1:0] local_tck,
  output logic [`SFP_LOCAL_N-1:0] local_tms,
  output logic [`SFP_LOCAL_N-1:0] local_trst_n,
  output logic [`SFP_LOCAL_N-1:0] local_tdo,
  output logic local_oe,
  input wire logic [`SFP_LOCAL_N-1:0] local_tdi_in,
  output logic [`SFP_FLAG_N-1:0] float_notify_flag,
  input wire logic local_passthru_in0,
  input wire logic local_passthru_in1,
  output logic local_passthru_out0,
  output logic local_passthru_out1,
  output logic local_passthru_oe
);
  // place master value at index m, slave value at the other
  function automatic logic [1:0] by_set(input logic m, input logic mv, input logic sv);
    return m ? {mv, sv} : {sv, mv};
  endfunction

  logic [`SFP_SY_W-1:0] sy_raw;
  logic [`SFP_SY_W-1:0] sy_s;
  logic mps;
  logic [1:0] tck2;
  logic [1:0] tms2;
  logic [1:0] tdi2;
  logic [1:0] pt0_2;
  logic [1:0] pt1_2;
  logic mst_tck;
  logic mst_tms;
  logic mst_tdi;
  logic slv_tdi;
  logic lp_en;
  logic trst_raw;
  logic arst_n;
  logic core_rst_n;
  logic tck_rise;
  logic trst_lvl;
  logic ret_data;
  logic pt_ok;
  logic pt_p0;
  logic pt_p1;
  logic [1:0] rsync_ff;
  logic tck_prev_ff;
  logic [2:0] tms_cnt_ff;
  sfp_pkg::sfp_tap_st_t tap_st_ff;
  sfp_pkg::sfp_sel_t sel_ff;
  logic [1:0] nxt_tdo_oe;
  logic nxt_local_oe;

  sfp_sel_if sif ();

  assign sy_raw = {local_passthru_in1, local_passthru_in0, local_tdi_in,
                   backplane_reset_mask, idle_reset_level, output_enable_n, slot_id,
                   master_port_select, backplane_passthru_in1, backplane_passthru_in0,
                   bp_tdi_in, bp_trst_n_in, bp_tms_in, bp_tck_in};

  sfp_sync #(.WIDTH(`SFP_SY_W)) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d_in(sy_raw),
    .q_out(sy_s)
  );

  sfp_port_sel u_sel (
    .sif(sif)
  );

  assign mps = sy_s[`SFP_SY_MPS];
  assign tck2 = sy_s[`SFP_SY_TCK +: 2];
  assign tms2 = sy_s[`SFP_SY_TMS +: 2];
  assign tdi2 = sy_s[`SFP_SY_TDI +: 2];
  assign pt0_2 = sy_s[`SFP_SY_PT0 +: 2];
  assign pt1_2 = sy_s[`SFP_SY_PT1 +: 2];
  assign mst_tck = tck2[mps];
  assign mst_tms = tms2[mps];
  assign mst_tdi = tdi2[mps];
  assign slv_tdi = tdi2[~mps];
  assign lp_en = ~sy_s[`SFP_SY_OEN];

  // raw master reset, asynchronous
  // unsynchronised pin here on purpose: reset must bite without a clock edge
  assign trst_raw = mps ? bp_trst_n_in[1] : bp_trst_n_in[0];
  // mask lets the master reset be ignored
  assign arst_n = rstn & (trst_raw | sy_s[`SFP_SY_MASK]);

  // release synchronised, assertion immediate
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rsync_ff <= 2'b00;
    end else begin
      rsync_ff <= {rsync_ff[0], 1'b1};
    end
  end
  assign core_rst_n = rsync_ff[1];

  assign sif.sel = sel_ff;

  always_ff @(posedge clk_sys or negedge core_rst_n) begin
    if (!core_rst_n) begin
      sel_ff <= `SFP_SEL_RST;
    end else begin
      sel_ff <= port_select;
    end
  end

  // master clock rising edges time the scan logic
  assign tck_rise = mst_tck & ~tck_prev_ff;

  // tracks whether the local taps sit in test-logic-reset
  always_ff @(posedge clk_sys or negedge core_rst_n) begin
    if (!core_rst_n) begin
      tap_st_ff <= sfp_pkg::SFP_TAP_TLR;
      tms_cnt_ff <= `SFP_TLR_LAST;
    end else if (tck_rise) begin
      case (tap_st_ff)
        sfp_pkg::SFP_TAP_TLR: begin
          if (!mst_tms) begin
            tap_st_ff <= sfp_pkg::SFP_TAP_RUN;
            tms_cnt_ff <= 3'h0;
          end
        end
        sfp_pkg::SFP_TAP_RUN: begin
          if (!mst_tms) begin
            tms_cnt_ff <= 3'h0;
          end else if (tms_cnt_ff == `SFP_TLR_LAST) begin
            tap_st_ff <= sfp_pkg::SFP_TAP_TLR;
          end else begin
            tms_cnt_ff <= tms_cnt_ff + 3'h1;
          end
        end
        default: begin
          tap_st_ff <= sfp_pkg::SFP_TAP_TLR;
        end
      endcase
    end
  end

  // idle level while taps rest in reset
  assign trst_lvl = (tap_st_ff == sfp_pkg::SFP_TAP_TLR) ? sy_s[`SFP_SY_IDLE] : 1'b1;

  // clock path stays on rstn so local clocks keep running through a test reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tck_prev_ff <= 1'b0;
      local_tck <= '0;
      bp_tck_out <= 2'b00;
      bp_tck_oe <= 2'b00;
    end else begin
      tck_prev_ff <= mst_tck;
      local_tck <= {`SFP_LOCAL_N{mst_tck}};
      bp_tck_out <= {2{mst_tck}};
      bp_tck_oe <= by_set(mps, 1'b0, lp_en);
    end
  end

  // return data from the lowest selected port
  always_comb begin
    if (sif.idx == 3'h0) begin
      ret_data = slv_tdi;
    end else begin
      ret_data = sy_s[`SFP_SY_LTDI + 32'(sif.idx) - 1];
    end
    nxt_tdo_oe = by_set(mps, sif.any, lp_en);
    nxt_local_oe = lp_en;
  end

  // six local ports driven from master
  always_ff @(posedge clk_sys or negedge core_rst_n) begin
    if (!core_rst_n) begin
      local_tms <= '0;
      local_tdo <= '1;
      local_trst_n <= '0;
      local_oe <= 1'b0;
      bp_tms_out <= 2'b00;
      bp_tms_oe <= 2'b00;
      bp_trst_n_out <= 2'b00;
      bp_trst_n_oe <= 2'b00;
      bp_tdo_out <= 2'b11;
      bp_tdo_oe <= 2'b00;
    end else begin
      for (int i = 0; i < `SFP_LOCAL_N; i++) begin
        local_tms[i] <= sel_ff[i+1] & mst_tms;
        local_tdo[i] <= sel_ff[i+1] ? mst_tdi : 1'b1;
      end
      // gated reset to every local port
      local_trst_n <= {`SFP_LOCAL_N{trst_lvl}};
      local_oe <= nxt_local_oe;
      bp_tms_out <= {2{sel_ff[0] & mst_tms}};
      bp_tms_oe <= by_set(mps, 1'b0, lp_en);
      bp_trst_n_out <= {2{trst_lvl}};
      bp_trst_n_oe <= by_set(mps, 1'b0, lp_en);
      bp_tdo_out <= by_set(mps, ret_data, sel_ff[0] ? mst_tdi : 1'b1);
      bp_tdo_oe <= nxt_tdo_oe;
    end
  end

  // flags track the same enables as the outputs
  always_ff @(posedge clk_sys or negedge core_rst_n) begin
    if (!core_rst_n) begin
      float_notify_flag <= `SFP_FLAG_RST;
    end else begin
      float_notify_flag <= {{3{~nxt_local_oe}}, ~nxt_tdo_oe};
    end
  end

  // pass-through only on ports 00 and 01
  assign pt_ok = sif.single & (sif.idx <= 3'h1);
  assign pt_p0 = sif.single & (sif.idx == 3'h0);
  assign pt_p1 = sif.single & (sif.idx == 3'h1);

  always_ff @(posedge clk_sys or negedge core_rst_n) begin
    if (!core_rst_n) begin
      backplane_passthru_out0 <= 2'b00;
      backplane_passthru_out1 <= 2'b00;
      backplane_passthru_oe <= 2'b00;
      local_passthru_out0 <= 1'b0;
      local_passthru_out1 <= 1'b0;
      local_passthru_oe <= 1'b0;
    end else begin
      // master outputs from selected port inputs
      backplane_passthru_out0 <= by_set(mps,
        pt_p0 ? pt0_2[~mps] : sy_s[`SFP_SY_LPT0], pt0_2[mps]);
      backplane_passthru_out1 <= by_set(mps,
        pt_p0 ? pt1_2[~mps] : sy_s[`SFP_SY_LPT1], pt1_2[mps]);
      // float both sides unless port 00 or 01 is the one port selected
      // port 00 side driven from master
      backplane_passthru_oe <= by_set(mps, pt_ok, pt_p0);
      // port 01 outputs from master inputs
      local_passthru_out0 <= pt0_2[mps];
      local_passthru_out1 <= pt1_2[mps];
      local_passthru_oe <= pt_p1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      slot_addr <= `SFP_SLOT_RST;
    end else begin
      slot_addr <= sy_s[`SFP_SY_SLOT +: `SFP_SLOT_W];
    end
  end
endmodule

/* testbench/sfp_fanout_monitor.sv */
// Purpose: port checker for the scan fan-out block
// Assumes: pins held steady across their sync delay
// Notes: pins reach outputs in three edges, trst assertion at once, selection in two
`timescale 1ns/1ps
module sfp_fanout_monitor (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [1:0] bp_tck_in,
  input wire logic [1:0] bp_trst_n_in,
  input wire logic [1:0] bp_tdo_oe,
  input wire logic [1:0] backplane_passthru_in0,
  input wire logic [1:0] backplane_passthru_oe,
  input wire logic master_port_select,
  input wire logic [7:0] slot_id,
  input wire logic [7:0] slot_addr,
  input wire logic output_enable_n,
  input wire logic backplane_reset_mask,
  input wire logic [6:0] port_select,
  input wire logic [5:0] local_tck,
  input wire logic [5:0] local_trst_n,
  input wire logic local_oe,
  input wire logic [4:0] float_notify_flag,
  input wire logic local_passthru_oe,
  input wire logic local_passthru_out0
);
  logic tck_m;
  logic trst_m;
  logic pt0_m;
  // raw select: the bench never moves it while these are active
  assign tck_m = bp_tck_in[master_port_select];
  assign trst_m = bp_trst_n_in[master_port_select];
  assign pt0_m = backplane_passthru_in0[master_port_select];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  chk_tck_copy: assert property ($rose(tck_m) |-> ##3 local_tck == 6'h3f)
    else $error("local clock not copied");
  chk_oe_float: assert property (output_enable_n [*4] |-> !local_oe)
    else $error("local ports not floated");
  chk_flag_local: assert property (float_notify_flag[4:2] == {3{!local_oe}})
    else $error("local float flag wrong");
  chk_flag_bp: assert property (float_notify_flag[1:0] == ~bp_tdo_oe)
    else $error("backplane float flag wrong");
  chk_pt_single: assert property (
    |backplane_passthru_oe |-> $past(port_select, 2) inside {7'h01, 7'h02})
    else $error("pass-through driven without single port");
  chk_pt_fwd: assert property (
    local_passthru_oe |-> local_passthru_out0 == $past(pt0_m, 3))
    else $error("pass-through output stale");
  chk_trst_async: assert property (
    !trst_m && !backplane_reset_mask |-> local_trst_n == 6'h00)
    else $error("local reset not forced");
  chk_slot_addr: assert property ($stable(slot_id) [*5] |-> slot_addr == slot_id)
    else $error("slot address wrong");
  cov_pt: cover property (local_passthru_oe);
  cov_trst: cover property (!trst_m);
  cov_tck: cover property ($rose(local_tck[0]));
endmodule

bind sfp_fanout sfp_fanout_monitor u_mon (.*);

/* testbench/sfp_far_chain.sv */
// Purpose: backplane clock source and local scan chains
// Assumes: clock stands low outside frames
// Notes: each chain is one flop deep, no reset
`timescale 1ns/1ps
module sfp_far_chain (
  input wire logic run,
  input wire logic [5:0] local_tck,
  input wire logic [5:0] local_tdo,
  output logic tck,
  output logic [5:0] local_tdi_in
);
  // single master clock
  // quarter-ns phase keeps tck edges off every clk_sys edge
  initial begin
    tck = 1'b0;
    #0.25;
    forever #62.5 tck = run ? ~tck : 1'b0;
  end
  for (genvar i = 0; i < 6; i++) begin : g_ch
    initial local_tdi_in[i] = 1'b1;
    always @(posedge local_tck[i]) local_tdi_in[i] <= local_tdo[i];
  end
endmodule

/* testbench/sfp_fanout_test.sv */
// Purpose: directed bench for the scan fan-out block
// Assumes: checks sampled 1 ns after an edge
// Notes: settle waits exceed the three edge latency
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module sfp_fanout_test;
  logic clk_sys, rstn, master_port_select, output_enable_n, idle_reset_level;
  logic backplane_reset_mask, local_oe, local_passthru_in0, local_passthru_in1;
  logic local_passthru_out0, local_passthru_out1, local_passthru_oe, far_tck, run;
  logic [1:0] bp_tck_in, bp_tck_out, bp_tck_oe, bp_tms_in, bp_tms_out, bp_tms_oe;
  logic [1:0] bp_trst_n_in, bp_trst_n_out, bp_trst_n_oe, bp_tdi_in, bp_tdo_out;
  logic [1:0] bp_tdo_oe, backplane_passthru_in0, backplane_passthru_in1;
  logic [1:0] backplane_passthru_out0, backplane_passthru_out1, backplane_passthru_oe;
  logic [7:0] slot_id, slot_addr;
  logic [6:0] port_select;
  logic [5:0] local_tck, local_tms, local_trst_n, local_tdo, local_tdi_in;
  logic [4:0] float_notify_flag;
  int errors = 0;
  int checks_done = 0;
  assign bp_tck_in = master_port_select ? {far_tck, 1'b0} : {1'b0, far_tck};
  sfp_fanout dut (.*);
  sfp_far_chain u_far (.run(run), .local_tck(local_tck), .local_tdo(local_tdo),
    .tck(far_tck), .local_tdi_in(local_tdi_in));
  always #2 clk_sys = ~clk_sys;
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic t_idle;
    #1;
    `CHK(float_notify_flag, 5'h1f)
    `CHK(local_tdo, 6'h3f)
    @(posedge clk_sys);
    rstn <= 1'b1;
    settle(5);
    `CHK(slot_addr, 8'ha5)
    $display("idle done");
  endtask
  task automatic t_clock;
    @(posedge clk_sys);
    run <= 1'b1;
    repeat (6) begin
      @(posedge far_tck);
      settle(4);
      `CHK(local_tck, 6'h3f)
      `CHK(bp_tck_out, 2'h3)
      @(negedge far_tck);
      settle(4);
      `CHK(local_tck, 6'h00)
    end
    run <= 1'b0;
    $display("clock done");
  endtask
  task automatic t_enable;
    @(posedge clk_sys);
    output_enable_n <= 1'b0;
    settle(4);
    `CHK({local_oe, float_notify_flag[4:2]}, 4'h8)
    output_enable_n <= 1'b1;
    settle(5);
    `CHK({local_oe, float_notify_flag[4:2]}, 4'h7)
    output_enable_n <= 1'b0;
    $display("enable done");
  endtask
  task automatic t_passthru;
    @(posedge clk_sys);
    port_select <= 7'h02;
    backplane_passthru_in0 <= 2'h1;
    local_passthru_in0 <= 1'b1;
    settle(4);
    `CHK({local_passthru_oe, local_passthru_out0, local_passthru_out1}, 3'h6)
    `CHK({backplane_passthru_out0[0], backplane_passthru_out1[0]}, 2'h2)
    `CHK(float_notify_flag[1:0], 2'h0)
    `CHK({local_tms, bp_tdo_out}, 8'h07)
    `CHK({bp_tck_oe, bp_tms_oe, bp_trst_n_oe}, 6'h2a)
    `CHK({bp_tms_out, bp_trst_n_out}, 4'h3)
    backplane_passthru_in0 <= 2'h0;
    backplane_passthru_in1 <= 2'h1;
    local_passthru_in0 <= 1'b0;
    local_passthru_in1 <= 1'b1;
    settle(4);
    `CHK({local_passthru_out0, local_passthru_out1}, 2'h1)
    `CHK({backplane_passthru_out0[0], backplane_passthru_out1[0]}, 2'h1)
    port_select <= 7'h06;
    settle(4);
    `CHK({local_passthru_oe, backplane_passthru_oe}, 3'h0)
    master_port_select <= 1'b1;
    settle(4);
    port_select <= 7'h02;
    backplane_passthru_in0 <= 2'h2;
    settle(4);
    `CHK({backplane_passthru_oe, local_passthru_out0}, 3'h5)
    port_select <= 7'h00;
    settle(4);
    master_port_select <= 1'b0;
    settle(4);
    $display("passthru done");
  endtask
  task automatic t_reset_gate;
    `CHK(local_trst_n, 6'h3f)
    @(posedge clk_sys);
    bp_trst_n_in <= 2'h2;
    #1;
    `CHK(local_trst_n, 6'h00)
    @(posedge clk_sys);
    bp_trst_n_in <= 2'h3;
    backplane_reset_mask <= 1'b1;
    settle(5);
    `CHK(local_trst_n, 6'h3f)
    bp_trst_n_in <= 2'h2;
    settle(4);
    `CHK(local_trst_n, 6'h3f)
    bp_trst_n_in <= 2'h3;
    backplane_reset_mask <= 1'b0;
    settle(4);
    idle_reset_level <= 1'b0;
    settle(4);
    `CHK(local_trst_n, 6'h00)
    $display("reset gate done");
  endtask
  initial begin
    #20000;
    errors++;
    summarize;
  end
  initial begin
    clk_sys = 1'b0;
    rstn = 1'b0;
    run = 1'b0;
    master_port_select = 1'b0;
    output_enable_n = 1'b1;
    idle_reset_level = 1'b1;
    backplane_reset_mask = 1'b0;
    local_passthru_in0 = 1'b0;
    local_passthru_in1 = 1'b0;
    bp_tms_in = 2'h3;
    bp_trst_n_in = 2'h3;
    bp_tdi_in = 2'h3;
    backplane_passthru_in0 = 2'h0;
    backplane_passthru_in1 = 2'h0;
    slot_id = 8'ha5;
    port_select = 7'h00;
    repeat (20) @(posedge clk_sys);
    t_idle;
    t_clock;
    t_enable;
    t_passthru;
    t_reset_gate;
    summarize;
  end
endmodule
